/* File: hdl/csr_exec.sv */
// Execution sequencer for stack, power-down, repeat, return, rotate and shift ops
`timescale 1ns/1ns
`default_nettype none
module csr_exec (
   input  wire logic             sys_clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             clk_en_i,
   input  wire logic             issue_i,
   input  wire csr_pkg::csr_op_t op_i,
   input  wire logic [15:0]      operand_i,
   input  wire logic [15:0]      operand_hi_i,
   input  wire logic [14:0]      literal_i,
   input  wire logic [3:0]       wsel_i,
   input  wire logic             periph_sfr_i,
   input  wire logic             alt_timing_i,
   input  wire logic [15:0]      stack_top_i,
   input  wire logic [39:0]      acc_i,
   input  wire logic             acc_sel_i,
   input  wire logic             wdt_timeout_i,
   output logic                  busy_o,
   output logic                  done_o,
   output logic [15:0]           result_o,
   output logic [15:0]           result_hi_o,
   output logic [3:0]            dest_sel_o,
   output logic                  wr_dest_o,
   output logic                  wr_dest_hi_o,
   output logic                  stack_push_o,
   output logic                  stack_pop_o,
   output logic                  pc_restore_o,
   output logic [39:0]           acc_o,
   output logic                  acc_wr_o,
   output logic                  acc_wr_sel_o,
   output logic                  flag_c_o,
   output logic                  flag_dc_o,
   output logic                  flag_n_o,
   output logic                  flag_ov_o,
   output logic                  flag_z_o,
   output logic                  acc_ov_a_o,
   output logic                  acc_ov_b_o,
   output logic                  acc_sat_a_o,
   output logic                  acc_sat_b_o,
   output logic                  watchdog_timeout_flag_o,
   output logic                  sleep_flag_o,
   output logic                  idle_mode_o,
   output logic                  sleep_mode_o,
   output logic                  stack_frame_active_o,
   output logic                  repeat_active_o,
   output logic [15:0]           repeat_count_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Datapath
   csr_res_if alu_bus ();
   csr_alu u_alu (.io(alu_bus.alu));
   assign alu_bus.op   = op_i;
   assign alu_bus.a    = operand_i;
   assign alu_bus.c_in = flag_c_o;

   // Signed shift: positive shifts right, negative shifts left
   function automatic logic [40:0] ash(input logic [39:0] a, input logic signed [15:0] s);
      logic [39:0] r;
      logic        ov;
      logic [5:0]  m;
      r  = a;
      ov = 1'b0;
      if (s >= 0) begin
         m = (s > 16'sd40) ? 6'd40 : 6'(s);
         r = 40'($signed(a) >>> m);
      end else begin
         m = (-s > 16'sd40) ? 6'd40 : 6'(-s);
         r  = a << m;
         ov = ($signed(r) >>> m) != $signed(a);
      end
      return {ov, r};
   endfunction

   function automatic logic zero16(input logic [15:0] v);
      return v == csr_pkg::ZERO16;
   endfunction

   wire logic [15:0] sh_reg  = operand_i;
   wire logic [15:0] sh_lit  = {{10{literal_i[5]}}, literal_i[5:0]};
   wire logic        is_lit  = (op_i == csr_pkg::CSR_OP_ASH_LIT);
   wire logic [40:0] sh_res  = ash(acc_i, is_lit ? sh_lit : sh_reg);
   wire logic        sh_sat  = sh_res[39] != sh_res[31];
   wire logic        is_ret  = (op_i == csr_pkg::CSR_OP_RETLIT) ||
                               (op_i == csr_pkg::CSR_OP_RETI) || (op_i == csr_pkg::CSR_OP_RET);
   wire logic        is_dbl  = (op_i == csr_pkg::CSR_OP_POP_D) ||
                               (op_i == csr_pkg::CSR_OP_PUSH_D);
   wire logic [3:0]  ret_cyc = alt_timing_i ? csr_pkg::CYC_RET_ALT : csr_pkg::CYC_RET;
   wire logic [3:0]  base_cyc = is_ret ? ret_cyc :
                                is_dbl ? csr_pkg::CYC_DOUBLE : csr_pkg::CYC_ONE;
   wire logic [3:0]  tot_cyc = base_cyc + (periph_sfr_i ? csr_pkg::CYC_SFR_ADD : 4'h0);
   wire logic [15:0] rpt_n   = (op_i == csr_pkg::CSR_OP_RPT_LIT) ?
                               {1'b0, literal_i} : operand_i;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   csr_pkg::csr_state_t state;
   csr_pkg::csr_state_t next_state;
   logic [3:0] cnt;
   wire logic start = issue_i && (state == csr_pkg::CSR_ST_IDLE);
   wire logic last  = (state == csr_pkg::CSR_ST_BUSY) && (cnt == csr_pkg::CYC_ONE);
   always_comb begin
      next_state = state;
      case (state)
         csr_pkg::CSR_ST_IDLE: if (issue_i && tot_cyc != csr_pkg::CYC_ONE) begin
            next_state = csr_pkg::CSR_ST_BUSY;
         end
         csr_pkg::CSR_ST_BUSY: if (last) begin
            next_state = csr_pkg::CSR_ST_IDLE;
         end
         default: next_state = csr_pkg::CSR_ST_IDLE;
      endcase
   end

   // Operation latched at issue; multi-cycle ops write on their final cycle
   csr_pkg::csr_op_t op_q;
   logic [15:0]      res_q;
   logic [15:0]      hi_q;
   wire logic fin = (start && tot_cyc == csr_pkg::CYC_ONE) || last;
   wire csr_pkg::csr_op_t op_f = start ? op_i : op_q;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= csr_pkg::CSR_ST_IDLE;
         cnt   <= 4'h0;
         op_q  <= csr_pkg::CSR_OP_NOP;
         res_q <= csr_pkg::ZERO16;
         hi_q  <= csr_pkg::ZERO16;
      end else if (clk_en_i) begin
         state <= next_state;
         if (start) begin
            cnt   <= tot_cyc - csr_pkg::CYC_ONE;
            op_q  <= op_i;
            res_q <= (op_i == csr_pkg::CSR_OP_RETLIT) ?
                     {6'h00, literal_i[9:0]} : operand_i;
            hi_q  <= operand_hi_i;
         end else if (state == csr_pkg::CSR_ST_BUSY) begin
            cnt <= cnt - csr_pkg::CYC_ONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_o <= 1'b0;  done_o <= 1'b0;  result_o <= csr_pkg::ZERO16;
         result_hi_o <= csr_pkg::ZERO16;  dest_sel_o <= 4'h0;
         wr_dest_o <= 1'b0;  wr_dest_hi_o <= 1'b0;
         stack_push_o <= 1'b0;  stack_pop_o <= 1'b0;  pc_restore_o <= 1'b0;
         acc_o <= 40'h00_0000_0000;  acc_wr_o <= 1'b0;  acc_wr_sel_o <= 1'b0;
         flag_c_o <= 1'b0;  flag_dc_o <= 1'b0;  flag_n_o <= 1'b0;
         flag_ov_o <= 1'b0;  flag_z_o <= 1'b0;
         acc_ov_a_o <= 1'b0;  acc_ov_b_o <= 1'b0;
         acc_sat_a_o <= 1'b0;  acc_sat_b_o <= 1'b0;
         watchdog_timeout_flag_o <= 1'b0;  sleep_flag_o <= 1'b0;
         idle_mode_o <= 1'b0;  sleep_mode_o <= 1'b0;
         stack_frame_active_o <= 1'b0;
         repeat_active_o <= 1'b0;  repeat_count_o <= csr_pkg::ZERO16;
      end else if (clk_en_i) begin
         busy_o       <= (next_state == csr_pkg::CSR_ST_BUSY);
         done_o       <= fin;
         wr_dest_o    <= 1'b0;
         wr_dest_hi_o <= 1'b0;
         stack_push_o <= 1'b0;
         stack_pop_o  <= 1'b0;
         pc_restore_o <= 1'b0;
         acc_wr_o     <= 1'b0;
         // Count completions, not requests: multi-cycle ops finish with the request already gone
         if (repeat_active_o && fin) begin
            repeat_count_o  <= repeat_count_o - csr_pkg::ONE16;
            repeat_active_o <= (repeat_count_o != csr_pkg::ZERO16);
         end
         if (start) begin
            dest_sel_o <= wsel_i;
         end
         if (fin) begin
            case (op_f)
               csr_pkg::CSR_OP_POP: begin
                  result_o    <= stack_top_i;
                  wr_dest_o   <= 1'b1;
                  stack_pop_o <= 1'b1;
               end
               csr_pkg::CSR_OP_POP_D: begin
                  result_o     <= stack_top_i;
                  result_hi_o  <= stack_top_i;
                  wr_dest_o    <= 1'b1;
                  wr_dest_hi_o <= 1'b1;
                  stack_pop_o  <= 1'b1;
               end
               csr_pkg::CSR_OP_PUSH: begin
                  result_o     <= start ? operand_i : res_q;
                  stack_push_o <= 1'b1;
               end
               csr_pkg::CSR_OP_PUSH_D: begin
                  result_o     <= res_q;
                  result_hi_o  <= hi_q;
                  stack_push_o <= 1'b1;
               end
               csr_pkg::CSR_OP_PWRDN: begin
                  sleep_mode_o            <= ~literal_i[0];
                  idle_mode_o             <= literal_i[0];
                  sleep_flag_o            <= ~literal_i[0];
                  watchdog_timeout_flag_o <= wdt_timeout_i;
               end
               csr_pkg::CSR_OP_RPT_LIT, csr_pkg::CSR_OP_RPT_REG: begin
                  repeat_count_o  <= rpt_n;
                  repeat_active_o <= 1'b1;
               end
               csr_pkg::CSR_OP_RETLIT, csr_pkg::CSR_OP_RETI, csr_pkg::CSR_OP_RET: begin
                  result_o             <= res_q;
                  wr_dest_o            <= (op_q == csr_pkg::CSR_OP_RETLIT);
                  pc_restore_o         <= 1'b1;
                  stack_frame_active_o <= 1'b0;
               end
               csr_pkg::CSR_OP_ROLC, csr_pkg::CSR_OP_RORC, csr_pkg::CSR_OP_SEXT,
               csr_pkg::CSR_OP_RLP, csr_pkg::CSR_OP_RRP, csr_pkg::CSR_OP_NEGATE: begin
                  result_o  <= alu_bus.r;
                  wr_dest_o <= 1'b1;
                  flag_n_o  <= alu_bus.r[csr_pkg::MSB];
                  flag_z_o  <= zero16(alu_bus.r);
                  flag_c_o  <= alu_bus.c_out;
                  if (op_f == csr_pkg::CSR_OP_NEGATE) begin
                     flag_dc_o <= alu_bus.dc_out;
                     flag_ov_o <= alu_bus.ov_out;
                  end
               end
               csr_pkg::CSR_OP_ASH_REG, csr_pkg::CSR_OP_ASH_LIT: begin
                  acc_o        <= sh_res[39:0];
                  acc_wr_o     <= 1'b1;
                  acc_wr_sel_o <= acc_sel_i;
                  if (acc_sel_i) begin
                     acc_ov_b_o  <= sh_res[40];
                     acc_sat_b_o <= acc_sat_b_o | sh_sat;
                  end else begin
                     acc_ov_a_o  <= sh_res[40];
                     acc_sat_a_o <= acc_sat_a_o | sh_sat;
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule : csr_exec
`default_nettype wire

/* File: hdl/csr_pkg.sv */
// Package of opcodes, widths, cycle counts and flag positions for the execution slice
package csr_pkg;
   localparam int unsigned DW = 16;
   localparam int unsigned AW = 40;
   typedef enum logic [4:0] {
      CSR_OP_NOP      = 5'h00,
      CSR_OP_POP      = 5'h01,
      CSR_OP_POP_D    = 5'h02,
      CSR_OP_PUSH     = 5'h03,
      CSR_OP_PUSH_D   = 5'h04,
      CSR_OP_PWRDN    = 5'h05,
      CSR_OP_RPT_LIT  = 5'h06,
      CSR_OP_RPT_REG  = 5'h07,
      CSR_OP_RETLIT   = 5'h08,
      CSR_OP_ROLC     = 5'h09,
      CSR_OP_RLP      = 5'h0A,
      CSR_OP_RORC     = 5'h0B,
      CSR_OP_RRP      = 5'h0C,
      CSR_OP_SEXT     = 5'h0D,
      CSR_OP_ASH_REG  = 5'h0E,
      CSR_OP_ASH_LIT  = 5'h0F,
      CSR_OP_NEGATE   = 5'h10,
      CSR_OP_RETI     = 5'h11,
      CSR_OP_RET      = 5'h12
   } csr_op_t;
   typedef enum logic [3:0] {
      CSR_ST_IDLE = 4'b0001,
      CSR_ST_BUSY = 4'b0010,
      CSR_ST_DONE = 4'b0100,
      CSR_ST_RSV  = 4'b1000
   } csr_state_t;
   localparam logic [3:0] CYC_ONE     = 4'h1;
   localparam logic [3:0] CYC_DOUBLE  = 4'h2;
   localparam logic [3:0] CYC_RET     = 4'h6;
   localparam logic [3:0] CYC_RET_ALT = 4'h5;
   localparam logic [3:0] CYC_SFR_ADD = 4'h1;
   localparam logic [15:0] ZERO16     = 16'h0000;
   localparam logic [15:0] ONE16      = 16'h0001;
   localparam int unsigned MSB        = 15;
   localparam int unsigned BYTE_MSB   = 7;
   localparam int unsigned LIT15_W    = 15;
   localparam int unsigned LIT10_W    = 10;
   localparam int unsigned LIT6_W     = 6;
   localparam int unsigned WSEL_W     = 4;
   localparam int unsigned SHAMT_LIM  = 16;
   localparam logic [15:0] SEXT_HI    = 16'hFF00;
endpackage : csr_pkg

/* File: hdl/csr_res_if.sv */
// Interface carrying operands and results between the decoder and its ALU
`timescale 1ns/1ns
`default_nettype none
interface csr_res_if;
   csr_pkg::csr_op_t op;
   logic [15:0]      a;
   logic             c_in;
   logic [15:0]      r;
   logic             c_out;
   logic             dc_out;
   logic             ov_out;
   modport core (output op, output a, output c_in,
                 input r, input c_out, input dc_out, input ov_out);
   modport alu  (input op, input a, input c_in,
                 output r, output c_out, output dc_out, output ov_out);
endinterface : csr_res_if
`default_nettype wire

/* File: hdl/csr_alu.sv */
// Single-cycle rotate, sign-extend and negate datapath
`timescale 1ns/1ns
`default_nettype none
module csr_alu (
   csr_res_if.alu io
);
   wire [16:0] neg_sum = {1'b0, ~io.a} + {1'b0, csr_pkg::ONE16};
   wire [4:0]  neg_lo  = {1'b0, ~io.a[3:0]} + 5'h01;
   always_comb begin
      io.r      = io.a;
      io.c_out  = io.c_in;
      io.dc_out = 1'b0;
      io.ov_out = 1'b0;
      case (io.op)
         csr_pkg::CSR_OP_ROLC: begin
            io.r     = {io.a[14:0], io.c_in};
            io.c_out = io.a[csr_pkg::MSB];
         end
         csr_pkg::CSR_OP_RLP: io.r = {io.a[14:0], io.a[csr_pkg::MSB]};
         csr_pkg::CSR_OP_RORC: begin
            io.r     = {io.c_in, io.a[15:1]};
            io.c_out = io.a[0];
         end
         csr_pkg::CSR_OP_RRP: io.r = {io.a[0], io.a[15:1]};
         csr_pkg::CSR_OP_SEXT: begin
            io.r     = io.a[csr_pkg::BYTE_MSB] ? (io.a | csr_pkg::SEXT_HI)
                                               : (io.a & ~csr_pkg::SEXT_HI);
            io.c_out = ~io.a[csr_pkg::BYTE_MSB];
         end
         csr_pkg::CSR_OP_NEGATE: begin
            io.r      = neg_sum[15:0];
            io.c_out  = neg_sum[16];
            io.dc_out = neg_lo[4];
            io.ov_out = (io.a == 16'h8000);
         end
         default: io.r = io.a;
      endcase
   end
endmodule : csr_alu
`default_nettype wire

/* File: sim/csr_exec_assertions.sv */
// Port checker for the execution sequencer
`timescale 1ns/1ns
`default_nettype none
module csr_exec_chk (
   input wire logic             sys_clk_i,
   input wire logic             arst_n_i,
   input wire logic             clk_en_i,
   input wire logic             issue_i,
   input wire csr_pkg::csr_op_t op_i,
   input wire logic [15:0]      operand_i,
   input wire logic [14:0]      literal_i,
   input wire logic             periph_sfr_i,
   input wire logic             alt_timing_i,
   input wire logic             busy_o,
   input wire logic             done_o,
   input wire logic [15:0]      result_o,
   input wire logic             flag_c_o,
   input wire logic             flag_n_o,
   input wire logic             flag_z_o,
   input wire logic             pc_restore_o,
   input wire logic [15:0]      repeat_count_o,
   input wire logic             repeat_active_o
);
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   csr_pkg::csr_op_t last_op;
   logic [15:0]      last_a;
   logic [14:0]      last_lit;
   wire logic take = clk_en_i && issue_i && !busy_o;
   wire logic one  = op_i inside {csr_pkg::CSR_OP_POP, csr_pkg::CSR_OP_PUSH, csr_pkg::CSR_OP_ROLC,
      csr_pkg::CSR_OP_RLP, csr_pkg::CSR_OP_RORC, csr_pkg::CSR_OP_RRP, csr_pkg::CSR_OP_NEGATE};
   wire logic pair = op_i inside {csr_pkg::CSR_OP_POP_D, csr_pkg::CSR_OP_PUSH_D};
   wire logic ret  = op_i inside {csr_pkg::CSR_OP_RETLIT, csr_pkg::CSR_OP_RETI, csr_pkg::CSR_OP_RET};
   // Operands are latched at issue so results can be tied back to their cause
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_op  <= csr_pkg::CSR_OP_NOP;
         last_a   <= 16'h0000;
         last_lit <= 15'h0000;
      end else if (take) begin
         last_op  <= op_i;
         last_a   <= operand_i;
         last_lit <= literal_i;
      end
   end
   sequence s_quiet4;
      !done_o [*4];
   endsequence
   sequence s_late2;
      !done_o ##1 done_o;
   endsequence
   AST_ONE_CYCLE: assert property (take && one && !periph_sfr_i |=> done_o)
      else $error("single cycle op did not finish in one cycle");
   AST_PAIR_TWO: assert property (take && pair && !periph_sfr_i |=> s_late2)
      else $error("pair op did not take two cycles");
   AST_RET_SIX: assert property (take && ret && !alt_timing_i && !periph_sfr_i |=> s_quiet4 ##1 s_late2)
      else $error("return did not take six cycles");
   AST_RET_FIVE: assert property (take && ret && alt_timing_i && !periph_sfr_i |=> s_quiet4 ##1 done_o)
      else $error("alternate return did not take five cycles");
   AST_SFR_EXTRA: assert property (take && one && periph_sfr_i |=> s_late2)
      else $error("peripheral operand did not add one cycle");
   AST_STACK_FLAGS: assert property (done_o && last_op inside {csr_pkg::CSR_OP_POP, csr_pkg::CSR_OP_PUSH, csr_pkg::CSR_OP_POP_D, csr_pkg::CSR_OP_PUSH_D} |-> $stable({flag_c_o, flag_n_o, flag_z_o}))
      else $error("stack op changed flags");
   AST_RLP_VALUE: assert property (done_o && last_op == csr_pkg::CSR_OP_RLP |-> result_o == {last_a[14:0], last_a[15]} && $stable(flag_c_o))
      else $error("plain rotate left wrong");
   AST_RRP_VALUE: assert property (done_o && last_op == csr_pkg::CSR_OP_RRP |-> result_o == {last_a[0], last_a[15:1]} && $stable(flag_c_o))
      else $error("plain rotate right wrong");
   AST_NEG_VALUE: assert property (done_o && last_op == csr_pkg::CSR_OP_NEGATE |-> result_o == ~last_a + 16'h0001)
      else $error("negation wrong");
   AST_RPT_COUNT: assert property (done_o && last_op == csr_pkg::CSR_OP_RPT_LIT |-> repeat_active_o && repeat_count_o == {1'b0, last_lit})
      else $error("repeat count not loaded");
   AST_RET_PC: assert property (done_o && last_op inside {csr_pkg::CSR_OP_RETI, csr_pkg::CSR_OP_RET} |-> pc_restore_o)
      else $error("return did not restore program counter");
endmodule // csr_exec_chk
bind csr_exec csr_exec_chk i_csr_exec_chk (
   .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .issue_i(issue_i),
   .op_i(op_i), .operand_i(operand_i), .literal_i(literal_i), .periph_sfr_i(periph_sfr_i),
   .alt_timing_i(alt_timing_i), .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
   .flag_c_o(flag_c_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .pc_restore_o(pc_restore_o),
   .repeat_count_o(repeat_count_o), .repeat_active_o(repeat_active_o));
`default_nettype wire

/* File: sim/testbench.sv */
// Directed self-checking bench for the execution sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam csr_pkg::csr_op_t ROT_OP [10] = '{csr_pkg::CSR_OP_ROLC, csr_pkg::CSR_OP_RORC,
      csr_pkg::CSR_OP_RLP, csr_pkg::CSR_OP_RRP, csr_pkg::CSR_OP_ROLC, csr_pkg::CSR_OP_RORC,
      csr_pkg::CSR_OP_NEGATE, csr_pkg::CSR_OP_NEGATE, csr_pkg::CSR_OP_SEXT, csr_pkg::CSR_OP_SEXT};
   localparam logic [15:0] ROT_A [10] = '{16'h8001, 16'h0001, 16'h8000, 16'h0003, 16'h0000,
      16'h0000, 16'h0001, 16'h0000, 16'h12F0, 16'h1234};
   localparam logic [15:0] ROT_R [10] = '{16'h0002, 16'h8000, 16'h0001, 16'h8001, 16'h0001,
      16'h0000, 16'hFFFF, 16'h0000, 16'hFFF0, 16'h0034};
   // Packed as negative, zero, carry
   localparam logic [2:0] ROT_F [10] = '{3'h1, 3'h5, 3'h1, 3'h5, 3'h0, 3'h2, 3'h4, 3'h3, 3'h4, 3'h1};
   localparam csr_pkg::csr_op_t STK_OP [4] = '{csr_pkg::CSR_OP_POP, csr_pkg::CSR_OP_PUSH,
      csr_pkg::CSR_OP_POP_D, csr_pkg::CSR_OP_PUSH_D};
   localparam csr_pkg::csr_op_t RET_OP [3] = '{csr_pkg::CSR_OP_RETLIT, csr_pkg::CSR_OP_RETI,
      csr_pkg::CSR_OP_RET};
   localparam csr_pkg::csr_op_t ACC_OP [4] = '{csr_pkg::CSR_OP_ASH_LIT, csr_pkg::CSR_OP_ASH_LIT,
      csr_pkg::CSR_OP_ASH_REG, csr_pkg::CSR_OP_ASH_REG};
   localparam logic [39:0] ACC_IN [4] = '{40'h0000000100, 40'h0000000100, 40'hF000000000, 40'h0000000001};
   localparam logic [15:0] ACC_SH [4] = '{16'h0004, 16'h003E, 16'h0004, 16'hFFFF};
   localparam logic [39:0] ACC_EX [4] = '{40'h0000000010, 40'h0000000400, 40'hFF00000000, 40'h0000000002};
   logic             sys_clk_i, arst_n_i, clk_en, issue, sfr, alt, acc_sel, wdt;
   csr_pkg::csr_op_t op;
   logic [15:0]      opnd, opnd_hi, stk, res, res_hi, rcnt;
   logic [14:0]      lit;
   logic [3:0]       wsel, dsel;
   logic [39:0]      acc, acc_out;
   logic             busy, done, wr, wr_hi, push, pop, pcr, accwr, accws, fc, fdc, fn, fov, fz;
   logic             ova, ovb, sata, satb, wdtf, slpf, idle, slp, stack_frame_active, ract;
   logic [2:0]       saved;
   int               bad_count, compares, n;
   csr_exec i_csr_exec (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en), .issue_i(issue),
      .op_i(op), .operand_i(opnd), .operand_hi_i(opnd_hi), .literal_i(lit), .wsel_i(wsel),
      .periph_sfr_i(sfr), .alt_timing_i(alt), .stack_top_i(stk), .acc_i(acc),
      .acc_sel_i(acc_sel), .wdt_timeout_i(wdt), .busy_o(busy), .done_o(done), .result_o(res),
      .result_hi_o(res_hi), .dest_sel_o(dsel), .wr_dest_o(wr), .wr_dest_hi_o(wr_hi),
      .stack_push_o(push), .stack_pop_o(pop), .pc_restore_o(pcr), .acc_o(acc_out),
      .acc_wr_o(accwr), .acc_wr_sel_o(accws), .flag_c_o(fc), .flag_dc_o(fdc), .flag_n_o(fn),
      .flag_ov_o(fov), .flag_z_o(fz), .acc_ov_a_o(ova), .acc_ov_b_o(ovb), .acc_sat_a_o(sata),
      .acc_sat_b_o(satb), .watchdog_timeout_flag_o(wdtf), .sleep_flag_o(slpf),
      .idle_mode_o(idle), .sleep_mode_o(slp), .stack_frame_active_o(stack_frame_active),
      .repeat_active_o(ract), .repeat_count_o(rcnt));
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Issue for one edge, then count edges up to the completion pulse
   task automatic run(input csr_pkg::csr_op_t o, input logic [15:0] a, input logic [14:0] l,
                      input logic s);
      @(negedge sys_clk_i);
      op = o;
      opnd = a;
      lit = l;
      sfr = s;
      issue = 1'b1;
      for (n = 1; n <= 20; n++) begin
         @(negedge sys_clk_i);
         issue = 1'b0;
         if (done === 1'b1) break;
      end
      if (n > 20) begin
         bad_count++;
         wrap_up();
      end
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      {arst_n_i, issue, sfr, alt, acc_sel} = 5'h00;
      {clk_en, wdt} = 2'h3;
      op = csr_pkg::CSR_OP_NOP;
      {opnd, opnd_hi, stk, lit} = 63'h0;
      wsel = 4'h5;
      acc = 40'h0;
      bad_count = 0;
      compares = 0;
      repeat (12) @(negedge sys_clk_i);
      arst_n_i = 1'b1;
      for (int i = 0; i < 10; i++) begin
         run(ROT_OP[i], ROT_A[i], 15'h0000, 1'b0);
         check(n, 1);
         check({res, fn, fz, wr, dsel}, {ROT_R[i], ROT_F[i][2:1], 1'b1, wsel});
         check(fc, ROT_F[i][0]);
         if (i > 5 && i < 8) check({fdc, fov}, {i == 7, 1'b0});
      end
      run(csr_pkg::CSR_OP_RLP, 16'h0001, 15'h0000, 1'b1);
      check({n, res}, {32'd2, 16'h0002});
      stk = 16'hABCD;
      opnd_hi = 16'h5678;
      saved = {fc, fn, fz};
      for (int i = 0; i < 4; i++) begin
         run(STK_OP[i], 16'h1234, 15'h0000, 1'b0);
         check(n, (i > 1) ? 2 : 1);
         check({fc, fn, fz, push, pop}, {saved, i[0], ~i[0]});
         if (i == 2) check({res, res_hi, wr_hi}, {16'hABCD, 16'hABCD, 1'b1});
         if (i == 3) check({res, res_hi}, {16'h1234, 16'h5678});
      end
      for (int t = 0; t < 2; t++) begin
         alt = t[0];
         for (int i = 0; i < 3; i++) begin
            run(RET_OP[i], 16'h0000, 15'h7ABC, 1'b0);
            check({n, pcr}, {6 - t, 1'b1});
            if (i == 0) check(res, 16'h02BC);
         end
      end
      alt = 1'b0;
      run(csr_pkg::CSR_OP_PWRDN, 16'h0000, 15'h0000, 1'b0);
      check({slp, idle, slpf, wdtf}, 4'hB);
      wdt = 1'b0;
      run(csr_pkg::CSR_OP_PWRDN, 16'h0000, 15'h0001, 1'b0);
      check({idle, wdtf}, 2'h2);
      run(csr_pkg::CSR_OP_RPT_LIT, 16'h0000, 15'h0002, 1'b0);
      check({n, ract, rcnt}, {32'd1, 1'b1, 16'h0002});
      for (int k = 1; k >= -1; k--) begin
         run(csr_pkg::CSR_OP_RLP, 16'h0001, 15'h0000, 1'b0);
         check(ract, k >= 0);
         if (k >= 0) check(rcnt, k[15:0]);
      end
      // Zero count is the boundary: the next op runs once
      run(csr_pkg::CSR_OP_RPT_REG, 16'h0000, 15'h0000, 1'b0);
      check({ract, rcnt}, 17'h10000);
      run(csr_pkg::CSR_OP_RLP, 16'h0001, 15'h0000, 1'b0);
      check(ract, 1'b0);
      for (int i = 0; i < 4; i++) begin
         acc = ACC_IN[i];
         acc_sel = i[0];
         run(ACC_OP[i], ACC_SH[i], ACC_SH[i][14:0], 1'b0);
         check({accwr, accws, acc_out, ova, ovb}, {1'b1, i[0], ACC_EX[i], 2'h0});
         check({sata, satb}, {i > 1, 1'b0});
      end
      @(negedge sys_clk_i);
      clk_en = 1'b0;
      op = csr_pkg::CSR_OP_RLP;
      opnd = 16'h4000;
      issue = 1'b1;
      repeat (3) begin
         @(negedge sys_clk_i);
         check(done, 1'b0);
      end
      clk_en = 1'b1;
      @(negedge sys_clk_i);
      issue = 1'b0;
      check({done, res}, {1'b1, 16'h8000});
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
